/* File: design/nfc_pkg.sv */
// package for the nand flash controller: command codes, address layout, pin timing
package nfc_pkg;
    // ----------------------------------------
    // command codes
    // ----------------------------------------
    localparam logic [7:0] CMD_READ      = 8'h00;
    localparam logic [7:0] CMD_READ_GO   = 8'h30;
    localparam logic [7:0] CMD_PROG      = 8'h80;
    localparam logic [7:0] CMD_PROG_GO   = 8'h10;
    localparam logic [7:0] CMD_ERASE     = 8'h60;
    localparam logic [7:0] CMD_ERASE_GO  = 8'hd0;
    localparam logic [7:0] CMD_READ_ID   = 8'h90;
    localparam logic [7:0] CMD_RESET     = 8'hff;
    localparam logic [7:0] CMD_STATUS    = 8'h70;
    localparam logic [7:0] CMD_RND_IN    = 8'h85;
    localparam logic [7:0] CMD_RND_OUT   = 8'h05;
    localparam logic [7:0] CMD_RND_OUT_GO = 8'he0;
    // ----------------------------------------
    // address layout
    // ----------------------------------------
    localparam int ADDR_W     = 28;
    localparam int COL_W      = 12;
    localparam int PAGE_BYTES = 2112;
    localparam int SPARE_BASE = 2048;
    localparam int BLOCKS     = 1024;
    // ----------------------------------------
    // strobe timing, ns and 8 ns cycles
    // ----------------------------------------
    localparam int CLK_NS     = 8;
    localparam int T_LOW_NS   = 25;
    localparam int T_HIGH_NS  = 25;
    localparam int T_ADL_NS   = 100;
    localparam int T_LOW_CYC  = (T_LOW_NS + CLK_NS - 1) / CLK_NS;
    localparam int T_HIGH_CYC = (T_HIGH_NS + CLK_NS - 1) / CLK_NS;
    localparam int T_ADL_CYC  = (T_ADL_NS + CLK_NS - 1) / CLK_NS;
    // ----------------------------------------
    // operation codes from the user side
    // ----------------------------------------
    localparam logic [2:0] OP_READ    = 3'h0;
    localparam logic [2:0] OP_PROG    = 3'h1;
    localparam logic [2:0] OP_ERASE   = 3'h2;
    localparam logic [2:0] OP_READ_ID = 3'h3;
    localparam logic [2:0] OP_RESET   = 3'h4;
    localparam logic [2:0] OP_STATUS  = 3'h5;
    localparam logic [2:0] OP_RND_IN  = 3'h6;
    localparam logic [2:0] OP_RND_OUT = 3'h7;
endpackage : nfc_pkg

/* File: design/nfc_fifo.sv */
// small synchronous fifo with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module nfc_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input  wire logic             sys_clk_in,
    input  wire logic             rst_n_in,
    input  wire logic [WIDTH-1:0] wr_data_in,
    input  wire logic             wr_valid_in,
    output logic                  wr_ready_out,
    output logic      [WIDTH-1:0] rd_data_out,
    output logic                  rd_valid_out,
    input  wire logic             rd_ready_in
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wp_q;
    logic [AW-1:0]    rp_q;
    logic [AW:0]      cnt_q;
    logic             wr_go;
    logic             rd_go;

    // ----------------------------------------
    // handshakes
    // ----------------------------------------
    assign wr_ready_out = (cnt_q != (AW+1)'(DEPTH));
    assign rd_valid_out = (cnt_q != '0);
    assign rd_data_out  = mem_q[rp_q];
    assign wr_go        = wr_valid_in && wr_ready_out;
    assign rd_go        = rd_valid_out && rd_ready_in;

    // storage
    always_ff @(posedge sys_clk_in) begin
        if (wr_go) begin
            mem_q[wp_q] <= wr_data_in;
        end
    end

    // pointers and fill count
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            wp_q  <= '0;
            rp_q  <= '0;
            cnt_q <= '0;
        end else begin
            if (wr_go) begin
                wp_q <= (wp_q == AW'(DEPTH-1)) ? '0 : wp_q + 1'b1;
            end
            if (rd_go) begin
                rp_q <= (rp_q == AW'(DEPTH-1)) ? '0 : rp_q + 1'b1;
            end
            cnt_q <= cnt_q + (AW+1)'(wr_go) - (AW+1)'(rd_go);
        end
    end

    a_fifo_no_over: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        cnt_q <= (AW+1)'(DEPTH))
        else $error("fifo count beyond depth");
endmodule : nfc_fifo
`default_nettype wire

/* File: design/nfc_ctrl.sv */
// nand flash controller: drives strobes and data lines of an external flash
`timescale 1ns/1ps
`default_nettype none
module nfc_ctrl #(
    parameter int DEPTH = 16
) (
    input  wire logic        sys_clk_in,
    input  wire logic        rst_n_in,
    input  wire logic        op_valid_in,
    input  wire logic [2:0]  op_code_in,
    input  wire logic [27:0] op_addr_in,
    input  wire logic [11:0] op_len_in,
    input  wire logic        wr_enable_in,
    output logic             op_ready_out,
    output logic             op_done_out,
    input  wire logic [7:0]  wdata_in,
    input  wire logic        wdata_valid_in,
    output logic             wdata_ready_out,
    output logic [7:0]       rdata_out,
    output logic             rdata_valid_out,
    input  wire logic        rdata_ready_in,
    output logic             chip_sel_n_out,
    output logic             cmd_latch_out,
    output logic             addr_latch_out,
    output logic             input_strobe_n_out,
    output logic             output_strobe_n_out,
    output logic             prog_lock_n_out,
    input  wire logic [7:0]  data_lines_in,
    output logic [7:0]       data_lines_out,
    output logic             data_lines_oe_out,
    input  wire logic        ready_busy_in
);
    // ----------------------------------------
    // declarations
    // ----------------------------------------
    typedef enum logic [3:0] {S_IDLE, S_CMD1, S_ADDR, S_DATA_W, S_CMD2, S_WAIT, S_DATA_R, S_DONE} nfc_state_t;
    nfc_state_t  state_q;
    logic [2:0]  op_q;
    logic [27:0] addr_q;
    logic [11:0] len_q;
    logic [11:0] cnt_q;
    logic [2:0]  acnt_q;
    logic [3:0]  tim_q;
    logic [1:0]  phase_q;   // 0 setup, 1 strobe low, 2 strobe high
    logic        rb_s1_q;
    logic        rb_s2_q;
    logic [7:0]  din_s1_q;
    logic [7:0]  din_s2_q;
    logic [7:0]  fi_data;
    logic        fi_valid;
    logic        fi_ready;
    logic        fo_valid;
    logic        fo_ready;
    logic [7:0]  fo_data;
    logic [7:0]  cap_q;
    logic        cap_v_q;
    logic [7:0]  cmd1;
    logic [7:0]  cmd2;
    logic        has_cmd2;
    logic [2:0]  acnt_max;
    logic [2:0]  acnt_first;
    logic        cycle_end;

    // ----------------------------------------
    // ready/busy synchroniser
    // ----------------------------------------
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rb_s1_q <= 1'b1;
            rb_s2_q <= 1'b1;
        end else begin
            rb_s1_q <= ready_busy_in;
            rb_s2_q <= rb_s1_q;
        end
    end

    // pin data bus passes two stages before capture
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            din_s1_q <= '0;
            din_s2_q <= '0;
        end else begin
            din_s1_q <= data_lines_in;
            din_s2_q <= din_s1_q;
        end
    end

    // command decode per operation
    always_comb begin
        cmd1 = nfc_pkg::CMD_READ;
        cmd2 = nfc_pkg::CMD_READ_GO;
        has_cmd2 = 1'b1;
        acnt_first = 3'd0;
        acnt_max = 3'd4;
        case (op_q)
            nfc_pkg::OP_READ: begin
                cmd1 = nfc_pkg::CMD_READ;
                cmd2 = nfc_pkg::CMD_READ_GO;
            end
            nfc_pkg::OP_PROG: begin
                cmd1 = nfc_pkg::CMD_PROG;
                cmd2 = nfc_pkg::CMD_PROG_GO;
            end
            nfc_pkg::OP_ERASE: begin
                cmd1 = nfc_pkg::CMD_ERASE;
                cmd2 = nfc_pkg::CMD_ERASE_GO;
                acnt_first = 3'd2;
            end
            nfc_pkg::OP_RND_IN: begin
                cmd1 = nfc_pkg::CMD_RND_IN;
                has_cmd2 = 1'b0;
                acnt_max = 3'd2;
            end
            nfc_pkg::OP_RND_OUT: begin
                cmd1 = nfc_pkg::CMD_RND_OUT;
                cmd2 = nfc_pkg::CMD_RND_OUT_GO;
                acnt_max = 3'd2;
            end
            nfc_pkg::OP_READ_ID: begin
                cmd1 = nfc_pkg::CMD_READ_ID;
                has_cmd2 = 1'b0;
                acnt_max = 3'd0;
            end
            nfc_pkg::OP_RESET: begin
                cmd1 = nfc_pkg::CMD_RESET;
                has_cmd2 = 1'b0;
                acnt_max = 3'd0;
            end
            default: begin
                cmd1 = nfc_pkg::CMD_STATUS;
                has_cmd2 = 1'b0;
                acnt_max = 3'd0;
            end
        endcase
    end

    // ----------------------------------------
    // write fifo and read fifo
    // ----------------------------------------
    nfc_fifo #(.WIDTH(8), .DEPTH(DEPTH)) u_wfifo (
        .sys_clk_in   (sys_clk_in),
        .rst_n_in     (rst_n_in),
        .wr_data_in   (wdata_in),
        .wr_valid_in  (wdata_valid_in),
        .wr_ready_out (wdata_ready_out),
        .rd_data_out  (fi_data),
        .rd_valid_out (fi_valid),
        .rd_ready_in  (fi_ready)
    );
    nfc_fifo #(.WIDTH(8), .DEPTH(DEPTH)) u_rfifo (
        .sys_clk_in   (sys_clk_in),
        .rst_n_in     (rst_n_in),
        .wr_data_in   (cap_q),
        .wr_valid_in  (fo_valid),
        .wr_ready_out (fo_ready),
        .rd_data_out  (fo_data),
        .rd_valid_out (rdata_valid_out),
        .rd_ready_in  (rdata_ready_in)
    );
    assign rdata_out = fo_data;
    assign fo_valid  = cap_v_q;
    // write byte is popped at the end of its strobe cycle
    assign fi_ready  = (state_q == S_DATA_W) && cycle_end;
    // one bus cycle ends when the high phase has timed out
    assign cycle_end = (phase_q == 2'd2) && (tim_q == 4'd0);
    assign op_ready_out = (state_q == S_IDLE);
    assign prog_lock_n_out = wr_enable_in;

    // ----------------------------------------
    // sequencer
    // ----------------------------------------
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state_q <= S_IDLE;
            op_q    <= nfc_pkg::OP_STATUS;
            addr_q  <= '0;
            len_q   <= '0;
            cnt_q   <= '0;
            acnt_q  <= '0;
            tim_q   <= '0;
            phase_q <= '0;
            op_done_out <= 1'b0;
            cap_q   <= '0;
            cap_v_q <= 1'b0;
        end else begin
            op_done_out <= 1'b0;
            cap_v_q <= 1'b0;
            if (tim_q != 4'd0) begin
                tim_q <= tim_q - 4'd1;
            end
            case (state_q)
                S_IDLE: begin
                    phase_q <= 2'd0;
                    // only reset or status while flash is busy
                    if (op_valid_in && (rb_s2_q || op_code_in == nfc_pkg::OP_RESET
                                        || op_code_in == nfc_pkg::OP_STATUS)) begin
                        op_q   <= op_code_in;
                        addr_q <= op_addr_in;
                        len_q  <= (op_len_in > 12'(nfc_pkg::PAGE_BYTES)) ?
                                  12'(nfc_pkg::PAGE_BYTES) : op_len_in;
                        cnt_q  <= '0;
                        state_q <= S_CMD1;
                    end
                end
                S_CMD1, S_ADDR, S_DATA_W, S_CMD2: begin
                    // strobe phases: setup, low, high
                    if (phase_q == 2'd0 && tim_q == 4'd0) begin
                        if (state_q != S_DATA_W || fi_valid) begin
                            phase_q <= 2'd1;
                            tim_q   <= 4'(nfc_pkg::T_LOW_CYC);
                        end
                    end else if (phase_q == 2'd1 && tim_q == 4'd0) begin
                        phase_q <= 2'd2;
                        tim_q   <= 4'(nfc_pkg::T_HIGH_CYC);
                    end else if (cycle_end) begin
                        phase_q <= 2'd0;
                        case (state_q)
                            S_CMD1: begin
                                acnt_q <= acnt_first;
                                if (acnt_max != 3'd0) begin
                                    state_q <= S_ADDR;
                                end else if (op_q == nfc_pkg::OP_RESET) begin
                                    state_q <= S_WAIT;
                                end else begin
                                    state_q <= S_DATA_R;
                                end
                            end
                            S_ADDR: begin
                                acnt_q <= acnt_q + 3'd1;
                                if (acnt_q + 3'd1 == acnt_max) begin
                                    tim_q <= 4'(nfc_pkg::T_ADL_CYC);
                                    if (op_q == nfc_pkg::OP_PROG || op_q == nfc_pkg::OP_RND_IN) begin
                                        state_q <= (len_q != 12'd0) ? S_DATA_W : S_DONE;
                                    end else begin
                                        state_q <= S_CMD2;
                                    end
                                end
                            end
                            S_DATA_W: begin
                                cnt_q <= cnt_q + 12'd1;
                                if (cnt_q + 12'd1 == len_q) begin
                                    state_q <= has_cmd2 ? S_CMD2 : S_DONE;
                                end
                            end
                            default: begin
                                state_q <= (op_q == nfc_pkg::OP_RND_OUT) ? S_DATA_R : S_WAIT;
                            end
                        endcase
                    end
                end
                S_WAIT: begin
                    // wait for the synchronised busy to rise again
                    if (tim_q == 4'd0 && phase_q == 2'd0) begin
                        phase_q <= 2'd1;
                        tim_q   <= 4'd4;
                    end else if (phase_q == 2'd1 && tim_q == 4'd0 && rb_s2_q) begin
                        phase_q <= 2'd0;
                        state_q <= (op_q == nfc_pkg::OP_READ) ? S_DATA_R : S_DONE;
                    end
                end
                S_DATA_R: begin
                    if (cnt_q == len_q) begin
                        state_q <= S_DONE;
                    end else if (phase_q == 2'd0 && tim_q == 4'd0 && fo_ready) begin
                        phase_q <= 2'd1;
                        tim_q   <= 4'(nfc_pkg::T_LOW_CYC);
                    end else if (phase_q == 2'd1 && tim_q == 4'd0) begin
                        cap_q   <= din_s2_q;
                        cap_v_q <= 1'b1;
                        cnt_q   <= cnt_q + 12'd1;
                        phase_q <= 2'd2;
                        tim_q   <= 4'(nfc_pkg::T_HIGH_CYC);
                    end else if (cycle_end) begin
                        phase_q <= 2'd0;
                    end
                end
                S_DONE: begin
                    op_done_out <= 1'b1;
                    state_q <= S_IDLE;
                end
                default: begin
                    state_q <= S_IDLE;
                end
            endcase
        end
    end

    // ----------------------------------------
    // pin drive
    // ----------------------------------------
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            chip_sel_n_out      <= 1'b1;
            cmd_latch_out       <= 1'b0;
            addr_latch_out      <= 1'b0;
            input_strobe_n_out  <= 1'b1;
            output_strobe_n_out <= 1'b1;
            data_lines_out      <= '0;
            data_lines_oe_out   <= 1'b0;
        end else begin
            chip_sel_n_out <= (state_q == S_IDLE);
            cmd_latch_out  <= (state_q == S_CMD1 || state_q == S_CMD2);
            addr_latch_out <= (state_q == S_ADDR);
            input_strobe_n_out <= !((state_q == S_CMD1 || state_q == S_ADDR || state_q == S_CMD2
                                     || state_q == S_DATA_W) && phase_q == 2'd1);
            output_strobe_n_out <= !(state_q == S_DATA_R && phase_q == 2'd1);
            data_lines_oe_out <= (state_q == S_CMD1 || state_q == S_ADDR || state_q == S_CMD2
                                  || state_q == S_DATA_W);
            case (state_q)
                S_CMD1: data_lines_out <= cmd1;
                S_CMD2: data_lines_out <= cmd2;
                S_DATA_W: data_lines_out <= fi_data;
                S_ADDR: begin
                    case (acnt_q)
                        3'd0: data_lines_out <= addr_q[7:0];
                        3'd1: data_lines_out <= {4'h0, addr_q[11:8]};
                        3'd2: data_lines_out <= addr_q[19:12];
                        default: data_lines_out <= addr_q[27:20];
                    endcase
                end
                default: data_lines_out <= data_lines_out;
            endcase
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    a_strobe_cs_low: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        !input_strobe_n_out |-> !chip_sel_n_out && data_lines_oe_out)
        else $error("write strobe without select or drive");
    a_no_drive_read: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        !output_strobe_n_out |-> !data_lines_oe_out)
        else $error("driving lines during read");
    a_cmd_addr_excl: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        !(cmd_latch_out && addr_latch_out))
        else $error("command and address latch both high");
    a_col_high_zero: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        state_q == S_ADDR && acnt_q == 3'd1 && phase_q == 2'd1 |=> data_lines_out[7:4] == 4'h0)
        else $error("column high nibble not zero");
    a_busy_only_safe: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        state_q == S_IDLE && $past(state_q) == S_IDLE && !rb_s2_q ##1 state_q == S_CMD1
        |-> op_q == nfc_pkg::OP_RESET || op_q == nfc_pkg::OP_STATUS)
        else $error("operation started while busy");
    a_erase_two_addr: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        state_q == S_ADDR && op_q == nfc_pkg::OP_ERASE |-> acnt_q >= 3'd2)
        else $error("erase sends column cycles");
    a_lock_follows: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        !wr_enable_in |-> !prog_lock_n_out)
        else $error("lock released without enable");
    a_len_bound: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        len_q <= 12'(nfc_pkg::PAGE_BYTES))
        else $error("length exceeds page");
endmodule : nfc_ctrl
`default_nettype wire

/* File: test/nfc_flash_model.sv */
// behavioural flash device on the far side of the controller pins
`timescale 1ns/1ps
`default_nettype none
module nfc_flash_model #(
    parameter int         BUSY_NS = 400,
    parameter logic [7:0] ID_BYTE = 8'h5a  // arbitrary value
) (
    input  wire logic       cs_n_in,
    input  wire logic       cmd_in,
    input  wire logic       adr_in,
    input  wire logic       istb_n_in,
    input  wire logic       ostb_n_in,
    input  wire logic       lock_n_in,
    input  wire logic [7:0] dq_in,
    output logic      [7:0] dq_out,
    output logic            drive_out,
    output logic            rb_out
);
    logic [7:0] pg [0:2111];
    logic [7:0] arr [logic [27:0]];
    logic [7:0] ab [0:3];
    logic [7:0] cmd_q = 8'h00;
    logic [9:0] log_q [$];
    int         na = 0;
    int         col = 0;
    int         mode = 0;
    int         bad = 0;
    event       go;
    // drives only while selected with output strobe low
    assign drive_out = !cs_n_in && !ostb_n_in;
    initial begin
        dq_out = 8'h00;
        rb_out = 1'b1;
        arr = '{default: 8'hff};
        foreach (pg[i]) pg[i] = 8'hff;
    end
    // busy span, chip select has no say in it
    always begin
        @(go);
        rb_out = 1'b0;
        #(BUSY_NS);
        rb_out = 1'b1;
    end
    // bytes latched on the rising input strobe
    always @(posedge istb_n_in) begin
        if (!cs_n_in && cmd_in) begin
            log_q.push_back({2'b10, dq_in});
            if (!rb_out && dq_in != 8'hff && dq_in != 8'h70) bad++;
            cmd_q = dq_in;
            na = 0;
            case (dq_in)
                8'h30: begin
                    foreach (pg[i]) pg[i] = arr[{ab[3], ab[2], 12'(i)}];
                    ->go;
                end
                8'h10: begin
                    if (lock_n_in) foreach (pg[i]) if (pg[i] !== 8'hff) arr[{ab[3], ab[2], 12'(i)}] = pg[i];
                    ->go;
                end
                8'h80: foreach (pg[i]) pg[i] = 8'hff;
                8'hd0: ->go;
                8'h70: mode = 1;
                8'h90: mode = 2;
                8'he0, 8'h00: mode = 0;
                8'h60, 8'hff, 8'h85, 8'h05: ;
                default: bad++;
            endcase
        end else if (!cs_n_in && adr_in) begin
            log_q.push_back({2'b01, dq_in});
            if (na < ((cmd_q == 8'h80 || cmd_q == 8'h00) ? 4 : 2)) ab[na] = dq_in;
            na++;
            col = {ab[1][3:0], ab[0]};
        end else if (!cs_n_in) begin
            log_q.push_back({2'b00, dq_in});
            if (col < 2112) pg[col] = dq_in;
            col++;
        end
    end
    // next byte on each falling output strobe, garbage once released
    always @(negedge ostb_n_in) begin
        if (!cs_n_in) begin
            dq_out = (mode == 1) ? {rb_out, 7'h60} : (mode == 2) ? ID_BYTE : pg[col % 2112];
            if (mode == 0) col++;
        end
    end
    always @(posedge ostb_n_in) dq_out = ~dq_out;
endmodule : nfc_flash_model
`default_nettype wire

/* File: test/test_nand_flash_cmd_interface.sv */
// self-checking bench: controller driving a behavioural flash
`timescale 1ns/1ps
`default_nettype none
module test_nand_flash_cmd_interface;
    logic        sys_clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        op_valid = 1'b0;
    logic [2:0]  op_code = 3'h0;
    logic [27:0] op_addr = 28'h0;
    logic [11:0] op_len = 12'h0;
    logic        wr_en = 1'b0;
    logic [7:0]  wdata = 8'h00;
    logic        wvalid = 1'b0;
    logic        rd_rdy = 1'b1;
    logic        op_ready, op_done, wready, rvalid, cs_n, cmd_l, adr_l, istb_n, ostb_n, lock_n, oe, fl_drv, rb;
    logic [7:0]  rdata, dout, fl_dq;
    logic [7:0]  rx_q [$];
    int          error_cnt = 0;
    int          checked = 0;
    wire  [7:0]  din = oe ? dout : fl_dq;
    nfc_ctrl DUT (.sys_clk_in(sys_clk), .rst_n_in(rst_n), .op_valid_in(op_valid), .op_code_in(op_code),
        .op_addr_in(op_addr), .op_len_in(op_len), .wr_enable_in(wr_en), .op_ready_out(op_ready),
        .op_done_out(op_done), .wdata_in(wdata), .wdata_valid_in(wvalid), .wdata_ready_out(wready),
        .rdata_out(rdata), .rdata_valid_out(rvalid), .rdata_ready_in(rd_rdy), .chip_sel_n_out(cs_n),
        .cmd_latch_out(cmd_l), .addr_latch_out(adr_l), .input_strobe_n_out(istb_n),
        .output_strobe_n_out(ostb_n), .prog_lock_n_out(lock_n), .data_lines_in(din),
        .data_lines_out(dout), .data_lines_oe_out(oe), .ready_busy_in(rb));
    nfc_flash_model FL (.cs_n_in(cs_n), .cmd_in(cmd_l), .adr_in(adr_l), .istb_n_in(istb_n), .ostb_n_in(ostb_n),
        .lock_n_in(lock_n), .dq_in(din), .dq_out(fl_dq), .drive_out(fl_drv), .rb_out(rb));
    always #4 sys_clk = ~sys_clk;
    // collect read stream, watch for both ends driving
    always @(posedge sys_clk) begin
        if (rvalid && rd_rdy) rx_q.push_back(rdata);
        if (oe && fl_drv) check(32'h1, 32'h0);
    end
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic put(input logic [7:0] b);
        @(posedge sys_clk);
        wdata <= b;
        wvalid <= 1'b1;
        do @(posedge sys_clk); while (wready !== 1'b1);
        wvalid <= 1'b0;
    endtask : put
    task automatic run_op(input logic [2:0] c, input logic [27:0] a, input logic [11:0] n);
        int k;
        k = 0;
        #1;
        while (op_ready !== 1'b1) begin
            @(posedge sys_clk);
            #1;
        end
        @(posedge sys_clk);
        op_valid <= 1'b1;
        op_code <= c;
        op_addr <= a;
        op_len <= n;
        do begin
            @(posedge sys_clk);
            #1;
            k++;
        end while (op_ready === 1'b1 && k < 9000);
        @(posedge sys_clk);
        op_valid <= 1'b0;
        while (op_done !== 1'b1 && k < 9000) begin
            @(posedge sys_clk);
            #1;
            k++;
        end
        check(32'(k < 9000), 32'h1);
        repeat (4) @(posedge sys_clk);
    endtask : run_op
    // compare pin bytes seen by the flash, then forget them
    task automatic exp_log(input logic [9:0] e[$]);
        check(32'(FL.log_q.size()), 32'(e.size()));
        foreach (e[i]) if (i < FL.log_q.size()) check(32'(FL.log_q[i]), 32'(e[i]));
        FL.log_q.delete();
    endtask : exp_log
    task automatic t_prog();
        logic [9:0] e[$];
        e = '{10'h280, 10'h1f8, 10'h107, 10'h141, 10'h100};
        wr_en <= 1'b1;
        for (int i = 0; i < 16; i++) put(8'ha0 + 8'(i));
        #1;
        check(32'(wready), 32'h0);
        check(32'(lock_n), 32'h1);
        run_op(nfc_pkg::OP_PROG, {16'h0041, 12'h7f8}, 12'd16);
        for (int i = 0; i < 16; i++) e.push_back({2'b00, 8'ha0 + 8'(i)});
        e.push_back(10'h210);
        exp_log(e);
        check(32'(FL.arr[{16'h0041, 12'h807}]), 32'haf);
        $display("test program finished");
    endtask : t_prog
    task automatic t_read();
        rd_rdy <= 1'b0;
        rx_q.delete();
        fork
            run_op(nfc_pkg::OP_READ, {16'h0041, 12'h7f8}, 12'd20);
            begin
                repeat (400) @(posedge sys_clk);
                check(32'(rvalid), 32'h1);
                rd_rdy <= 1'b1;
            end
        join
        exp_log('{10'h200, 10'h1f8, 10'h107, 10'h141, 10'h100, 10'h230});
        check(32'(rx_q.size()), 32'd20);
        foreach (rx_q[i]) check(32'(rx_q[i]), (i < 16) ? 32'ha0 + 32'(i) : 32'hff);
        $display("test read finished");
    endtask : t_read
    task automatic t_misc();
        logic [2:0] ops [3] = '{nfc_pkg::OP_READ_ID, nfc_pkg::OP_STATUS, nfc_pkg::OP_RESET};
        logic [9:0] cmds [3] = '{10'h290, 10'h270, 10'h2ff};
        logic [7:0] ans [3] = '{8'h5a, 8'he0, 8'h00};
        run_op(nfc_pkg::OP_ERASE, {16'h0041, 12'h000}, 12'd0);
        exp_log('{10'h260, 10'h141, 10'h100, 10'h2d0});
        wr_en <= 1'b0;
        put(8'h3c);
        #1;
        check(32'(lock_n), 32'h0);
        run_op(nfc_pkg::OP_PROG, 28'h0100000, 12'd1);
        check(32'(FL.arr.exists(28'h0100000)), 32'h0);
        FL.log_q.delete();
        foreach (ops[i]) begin
            rx_q.delete();
            run_op(ops[i], 28'h0, (i < 2) ? 12'd1 : 12'd0);
            exp_log('{cmds[i]});
            check(32'(rx_q.size()), (i < 2) ? 32'h1 : 32'h0);
            if (rx_q.size() > 0) check(32'(rx_q[0]), 32'(ans[i]));
        end
        run_op(nfc_pkg::OP_RND_OUT, 28'h0000005, 12'd1);
        exp_log('{10'h205, 10'h105, 10'h100, 10'h2e0});
        check(32'(rx_q.size()), 32'h1);
        put(8'h77);
        run_op(nfc_pkg::OP_RND_IN, 28'h0000834, 12'd1);
        exp_log('{10'h285, 10'h134, 10'h108, 10'h077});
        $display("test erase, lock and single commands finished");
    endtask : t_misc
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : end_sim
    // main sequence after 20 cycles of reset
    initial begin
        repeat (20) @(posedge sys_clk);
        rst_n <= 1'b1;
        t_prog();
        t_read();
        t_misc();
        check(32'(FL.bad), 32'h0);
        end_sim();
    end
    // watchdog, about twenty times the expected run
    initial begin
        #(200_000);
        check(32'h0, 32'h1);
        end_sim();
    end
endmodule : test_nand_flash_cmd_interface
`default_nettype wire
